/* File: logic/oag_top.sv */
`timescale 1ns/10ps
module oag_top #(
    parameter int DW   = 16,
    parameter int NREG = 16
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire logic                 instr_valid,
    input  wire logic [2:0]           instr_class,
    input  wire logic [3:0]           src_mode,
    input  wire logic [3:0]           dst_mode,
    input  wire logic [3:0]           src_reg,
    input  wire logic [3:0]           dst_reg,
    input  wire logic [3:0]           offset_sel,
    input  wire logic [DW-1:0]        lit_field,
    input  wire logic [DW-1:0]        file_addr,
    input  wire logic                 x_ptr_sel,
    input  wire logic                 y_ptr_sel,
    input  wire logic [1:0]           x_mac_mode,
    input  wire logic [1:0]           y_mac_mode,
    input  wire logic [1:0]           x_step_sel,
    input  wire logic [1:0]           y_step_sel,
    input  wire logic [NREG*DW-1:0]   wreg_vals,
    output logic                      done_q,
    output logic                      illegal_q,
    output logic                      src_mem_q,
    output logic                      dst_mem_q,
    output logic [DW-1:0]             src_ea_q,
    output logic [DW-1:0]             dst_ea_q,
    output logic                      src_is_reg_q,
    output logic                      dst_is_reg_q,
    output logic                      src_is_data_q,
    output logic [DW-1:0]             src_data_q,
    output logic                      x_rd_q,
    output logic [DW-1:0]             x_addr_q,
    output logic                      y_rd_q,
    output logic [DW-1:0]             y_addr_q,
    output logic                      lit_valid_q,
    output logic [DW-1:0]             lit_q,
    output logic                      implied_q,
    output logic                      wb_a_en_q,
    output logic [3:0]                wb_a_idx_q,
    output logic [DW-1:0]             wb_a_data_q,
    output logic                      wb_b_en_q,
    output logic [3:0]                wb_b_idx_q,
    output logic [DW-1:0]             wb_b_data_q
);

    // Picks one working register out of the flattened register file.
    function automatic logic [DW-1:0] reg_at(input logic [3:0] idx);
        reg_at = wreg_vals[idx*DW +: DW];
    endfunction

    // Maps a prefetch step selector to its byte count.
    function automatic logic [DW-1:0] mac_step(input logic [1:0] sel);
        case (sel)
            2'h0:    mac_step = oag_pkg::OAG_MAC_STEP2;
            2'h1:    mac_step = oag_pkg::OAG_MAC_STEP4;
            default: mac_step = oag_pkg::OAG_MAC_STEP6;
        endcase
    endfunction

    // Translates a prefetch mode into the shared operand mode.
    function automatic logic [3:0] mac_to_mode(input logic [1:0] m);
        case (m)
            oag_pkg::OAG_MAC_POST:  mac_to_mode = oag_pkg::OAG_POST_INC;
            oag_pkg::OAG_MAC_INDEX: mac_to_mode = oag_pkg::OAG_INDEXED;
            default:                mac_to_mode = oag_pkg::OAG_IND;
        endcase
    endfunction

    logic            take;
    logic            is_mac;
    logic [DW-1:0]   offset_val;
    logic [DW-1:0]   src_base;
    logic [DW-1:0]   dst_base;
    logic [3:0]      x_idx;
    logic [3:0]      y_idx;
    logic [3:0]      gen_mode [4];
    logic [DW-1:0]   gen_base [4];
    logic [DW-1:0]   gen_off  [4];
    logic [DW-1:0]   gen_step [4];
    logic [DW-1:0]   gen_ea   [4];
    logic [DW-1:0]   gen_new  [4];
    logic            gen_mod  [4];
    logic            src_legal;
    logic            dst_legal;
    logic            mac_legal;
    logic            bad;
    logic            src_mem;
    logic            dst_mem;

    assign take   = clk_en && instr_valid;
    assign is_mac = (instr_class == oag_pkg::OAG_CL_MAC);

    // One offset selector serves both move operands.
    assign offset_val = reg_at(offset_sel);
    assign src_base   = reg_at(src_reg);
    assign dst_base   = reg_at(dst_reg);

    // Prefetch pointers are drawn only from the fixed X and Y pairs.
    assign x_idx = x_ptr_sel ? oag_pkg::OAG_X_PTR_B_IDX
                             : oag_pkg::OAG_X_PTR_A_IDX;
    assign y_idx = y_ptr_sel ? oag_pkg::OAG_Y_PTR_B_IDX
                             : oag_pkg::OAG_Y_PTR_A_IDX;

    // Operand slots: 0 source, 1 destination, 2 X prefetch, 3 Y prefetch.
    always_comb begin
        gen_mode[0] = src_mode;
        gen_mode[1] = dst_mode;
        gen_mode[2] = mac_to_mode(x_mac_mode);
        gen_mode[3] = mac_to_mode(y_mac_mode);
        gen_base[0] = src_base;
        gen_base[1] = dst_base;
        gen_base[2] = reg_at(x_idx);
        gen_base[3] = reg_at(y_idx);
        gen_off[0]  = (src_mode == oag_pkg::OAG_LIT_OFF) ? lit_field
                                                         : offset_val;
        gen_off[1]  = (dst_mode == oag_pkg::OAG_LIT_OFF) ? lit_field
                                                         : offset_val;
        gen_off[2]  = offset_val;
        gen_off[3]  = offset_val;
        gen_step[0] = oag_pkg::OAG_WORD_STEP;
        gen_step[1] = oag_pkg::OAG_WORD_STEP;
        gen_step[2] = mac_step(x_step_sel);
        gen_step[3] = mac_step(y_step_sel);
    end

    // One address adder per operand slot.
    for (genvar g = 0; g < 4; g++) begin : g_adder
        oag_ea_adder #(
            .DW       (DW)
        ) u_adder (
            .base     (gen_base[g]),
            .offset   (gen_off[g]),
            .step     (gen_step[g]),
            .mode     (gen_mode[g]),
            .ea       (gen_ea[g]),
            .new_ptr  (gen_new[g]),
            .modifies (gen_mod[g])
        );
    end

    // Mode legality for source and destination of the current class.
    oag_mode_check u_src_chk (
        .cls   (instr_class),
        .mode  (src_mode),
        .legal (src_legal)
    );
    oag_mode_check u_dst_chk (
        .cls   (instr_class),
        .mode  (dst_mode),
        .legal (dst_legal)
    );

    // Indexing is only open to the B pointer of each space.
    assign mac_legal =
        (x_mac_mode <= oag_pkg::OAG_MAC_INDEX)
        && (y_mac_mode <= oag_pkg::OAG_MAC_INDEX)
        && (x_mac_mode != oag_pkg::OAG_MAC_INDEX || x_ptr_sel)
        && (y_mac_mode != oag_pkg::OAG_MAC_INDEX || y_ptr_sel)
        && (x_step_sel != 2'h3 || x_mac_mode != oag_pkg::OAG_MAC_POST)
        && (y_step_sel != 2'h3 || y_mac_mode != oag_pkg::OAG_MAC_POST);

    // Only general, move and accumulator classes are checked per operand.
    always_comb begin
        case (instr_class)
            oag_pkg::OAG_CL_GENERAL: bad = !src_legal;
            oag_pkg::OAG_CL_MOVE,
            oag_pkg::OAG_CL_ACCUM:   bad = !src_legal || !dst_legal;
            oag_pkg::OAG_CL_MAC:     bad = !mac_legal;
            default:                 bad = 1'b0;
        endcase
    end

    // A source touches memory unless it is a register or a literal; a destination unless it is a register.
    assign src_mem = (src_mode != oag_pkg::OAG_REG_DIR)
                  && (src_mode != oag_pkg::OAG_LIT8)
                  && (src_mode != oag_pkg::OAG_LIT16);
    assign dst_mem = (dst_mode != oag_pkg::OAG_REG_DIR);

    // Completion flag pulses once per accepted instruction, refusal flag only for an illegal one.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            done_q    <= 1'b0;
            illegal_q <= 1'b0;
        end else if (clk_en) begin
            done_q    <= instr_valid;
            illegal_q <= instr_valid && bad;
        end
    end

    // Source addresses for ordinary, move and accumulator operands, destination
    // addresses for move and accumulator only; illegal combinations access nothing.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            src_mem_q     <= 1'b0;
            dst_mem_q     <= 1'b0;
            src_is_reg_q  <= 1'b0;
            dst_is_reg_q  <= 1'b0;
            src_is_data_q <= 1'b0;
            src_ea_q      <= oag_pkg::OAG_RESET_WORD;
            dst_ea_q      <= oag_pkg::OAG_RESET_WORD;
            src_data_q    <= oag_pkg::OAG_RESET_WORD;
        end else if (take) begin
            src_mem_q     <= 1'b0;
            dst_mem_q     <= 1'b0;
            src_is_reg_q  <= 1'b0;
            dst_is_reg_q  <= 1'b0;
            src_is_data_q <= 1'b0;
            if (!bad && (instr_class == oag_pkg::OAG_CL_GENERAL
                      || instr_class == oag_pkg::OAG_CL_MOVE
                      || instr_class == oag_pkg::OAG_CL_ACCUM)) begin
                src_mem_q <= src_mem;
                src_ea_q  <= (src_mode == oag_pkg::OAG_FILE_DIR)
                           ? file_addr : gen_ea[0];
                src_is_reg_q <= (src_mode == oag_pkg::OAG_REG_DIR);
                src_is_data_q <= !src_mem;
                case (src_mode)
                    oag_pkg::OAG_REG_DIR: src_data_q <= src_base;
                    oag_pkg::OAG_LIT8: src_data_q <= DW'(
                        lit_field[oag_pkg::OAG_SHORT_LIT_W-1:0]);
                    oag_pkg::OAG_LIT16: src_data_q <= lit_field;
                    default: src_data_q <= oag_pkg::OAG_RESET_WORD;
                endcase
                if (instr_class != oag_pkg::OAG_CL_GENERAL) begin
                    dst_mem_q    <= dst_mem;
                    dst_is_reg_q <= !dst_mem;
                    dst_ea_q     <= (dst_mode == oag_pkg::OAG_FILE_DIR)
                                  ? file_addr : gen_ea[1];
                end
            end
        end
    end

    // Prefetch reads: X pointers feed only X space, Y only Y space.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            x_rd_q   <= 1'b0;
            y_rd_q   <= 1'b0;
            x_addr_q <= oag_pkg::OAG_RESET_WORD;
            y_addr_q <= oag_pkg::OAG_RESET_WORD;
        end else if (take) begin
            x_rd_q <= is_mac && !bad;
            y_rd_q <= is_mac && !bad;
            if (is_mac && !bad) begin
                x_addr_q <= gen_ea[2];
                y_addr_q <= gen_ea[3];
            end
        end
    end

    // Literal operands of branch and interrupt-disable instructions, and
    // the implied-operand marker.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lit_valid_q <= 1'b0;
            lit_q       <= oag_pkg::OAG_RESET_WORD;
            implied_q   <= 1'b0;
        end else if (take) begin
            lit_valid_q <= (instr_class == oag_pkg::OAG_CL_BRANCH)
                        || (instr_class == oag_pkg::OAG_CL_DISABLE);
            implied_q   <= (instr_class == oag_pkg::OAG_CL_IMPLIED);
            if (instr_class == oag_pkg::OAG_CL_BRANCH) begin
                lit_q <= lit_field;
            end else if (instr_class == oag_pkg::OAG_CL_DISABLE) begin
                lit_q <= DW'(lit_field[oag_pkg::OAG_DISABLE_LIT_W-1:0]);
            end
        end
    end

    // Pointer write-back: port A serves source or X, port B destination
    // or Y, each to the register that supplied the pointer.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wb_a_en_q   <= 1'b0;
            wb_b_en_q   <= 1'b0;
            wb_a_idx_q  <= 4'h0;
            wb_b_idx_q  <= 4'h0;
            wb_a_data_q <= oag_pkg::OAG_RESET_WORD;
            wb_b_data_q <= oag_pkg::OAG_RESET_WORD;
        end else if (take) begin
            wb_a_en_q <= 1'b0;
            wb_b_en_q <= 1'b0;
            if (!bad && is_mac) begin
                wb_a_en_q   <= gen_mod[2];
                wb_a_idx_q  <= x_idx;
                wb_a_data_q <= gen_new[2];
                wb_b_en_q   <= gen_mod[3];
                wb_b_idx_q  <= y_idx;
                wb_b_data_q <= gen_new[3];
            end else if (!bad && (instr_class == oag_pkg::OAG_CL_GENERAL
                               || instr_class == oag_pkg::OAG_CL_MOVE
                               || instr_class == oag_pkg::OAG_CL_ACCUM)) begin
                wb_a_en_q   <= gen_mod[0];
                wb_a_idx_q  <= src_reg;
                wb_a_data_q <= gen_new[0];
                wb_b_en_q   <= gen_mod[1]
                    && (instr_class != oag_pkg::OAG_CL_GENERAL);
                wb_b_idx_q  <= dst_reg;
                wb_b_data_q <= gen_new[1];
            end
        end
    end

    // Checks on the registered answer of each accepted instruction.
    a_file_direct: assert property (@(posedge core_clk) disable iff (reset)
        take && !bad && instr_class == oag_pkg::OAG_CL_GENERAL
        && src_mode == oag_pkg::OAG_FILE_DIR
        |=> src_mem_q && src_ea_q == $past(file_addr))
        else $error("file direct address wrong");
    a_reg_direct: assert property (@(posedge core_clk) disable iff (reset)
        take && !bad && src_mode == oag_pkg::OAG_REG_DIR
        && instr_class == oag_pkg::OAG_CL_MOVE
        |=> !src_mem_q && src_data_q == $past(src_base))
        else $error("register direct operand wrong");
    a_indirect_ea: assert property (@(posedge core_clk) disable iff (reset)
        take && !bad && instr_class == oag_pkg::OAG_CL_GENERAL
        && src_mode == oag_pkg::OAG_IND
        |=> src_ea_q == $past(src_base) && !wb_a_en_q)
        else $error("indirect address wrong");
    a_post_step: assert property (@(posedge core_clk) disable iff (reset)
        take && !bad && instr_class == oag_pkg::OAG_CL_GENERAL
        && src_mode == oag_pkg::OAG_POST_INC
        |=> src_ea_q == $past(src_base) && wb_a_en_q
        && wb_a_data_q == DW'($past(src_base) + 16'h0002))
        else $error("post-modify wrong");
    a_pre_step: assert property (@(posedge core_clk) disable iff (reset)
        take && !bad && instr_class == oag_pkg::OAG_CL_GENERAL
        && src_mode == oag_pkg::OAG_PRE_DEC
        |=> wb_a_en_q && src_ea_q == wb_a_data_q
        && src_ea_q == DW'($past(src_base) - 16'h0002))
        else $error("pre-modify wrong");
    a_indexed_ea: assert property (@(posedge core_clk) disable iff (reset)
        take && !bad && instr_class == oag_pkg::OAG_CL_MOVE
        && src_mode == oag_pkg::OAG_INDEXED
        |=> src_ea_q == DW'($past(src_base) + $past(offset_val)))
        else $error("indexed address wrong");
    a_mac_route: assert property (@(posedge core_clk) disable iff (reset)
        take && !bad && is_mac && x_mac_mode == oag_pkg::OAG_MAC_IND
        && y_mac_mode == oag_pkg::OAG_MAC_IND
        |=> x_rd_q && y_rd_q
        && x_addr_q == $past(reg_at(x_idx)) && y_addr_q == $past(gen_base[3]))
        else $error("prefetch routing wrong");
    a_mac_index_a: assert property (@(posedge core_clk) disable iff (reset)
        take && is_mac && !x_ptr_sel && x_mac_mode == oag_pkg::OAG_MAC_INDEX
        |=> illegal_q && !x_rd_q)
        else $error("indexing through A pointer accepted");
    a_dis_lit: assert property (@(posedge core_clk) disable iff (reset)
        take && instr_class == oag_pkg::OAG_CL_DISABLE
        |=> lit_valid_q && lit_q[15:14] == 2'h0
        && lit_q[13:0] == $past(lit_field[13:0]))
        else $error("disable literal wrong");
    a_nop_quiet: assert property (@(posedge core_clk) disable iff (reset)
        take && instr_class == oag_pkg::OAG_CL_NOP
        |=> done_q && !src_mem_q && !dst_mem_q && !x_rd_q && !y_rd_q
        && !wb_a_en_q && !wb_b_en_q && !lit_valid_q)
        else $error("no-operation produced an access");

endmodule // oag_top

/* File: logic/oag_pkg.sv */
package oag_pkg;

    // Operand addressing modes shared by the general, move and accumulator
    // paths.
    typedef enum logic [3:0] {
        OAG_FILE_DIR = 4'h0,
        OAG_REG_DIR  = 4'h1,
        OAG_IND      = 4'h2,
        OAG_POST_INC = 4'h3,
        OAG_POST_DEC = 4'h4,
        OAG_PRE_INC  = 4'h5,
        OAG_PRE_DEC  = 4'h6,
        OAG_INDEXED  = 4'h7,
        OAG_LIT_OFF  = 4'h8,
        OAG_LIT8     = 4'h9,
        OAG_LIT16    = 4'hA
    } oag_mode_e;

    // Instruction classes as seen by the address generator.
    typedef enum logic [2:0] {
        OAG_CL_NOP     = 3'h0,
        OAG_CL_GENERAL = 3'h1,
        OAG_CL_MOVE    = 3'h2,
        OAG_CL_ACCUM   = 3'h3,
        OAG_CL_MAC     = 3'h4,
        OAG_CL_BRANCH  = 3'h5,
        OAG_CL_DISABLE = 3'h6,
        OAG_CL_IMPLIED = 3'h7
    } oag_class_e;

    // Prefetch addressing modes of the multiply-accumulate class.
    typedef enum logic [1:0] {
        OAG_MAC_IND   = 2'h0,
        OAG_MAC_POST  = 2'h1,
        OAG_MAC_INDEX = 2'h2
    } oag_mac_mode_e;

    // Working register numbers of the four prefetch pointers.
    localparam logic [3:0] OAG_X_PTR_A_IDX = 4'h8;
    localparam logic [3:0] OAG_X_PTR_B_IDX = 4'h9;
    localparam logic [3:0] OAG_Y_PTR_A_IDX = 4'hA;
    localparam logic [3:0] OAG_Y_PTR_B_IDX = 4'hB;

    // Byte steps for pointer modification.
    localparam logic [15:0] OAG_WORD_STEP = 16'h0002;
    localparam logic [15:0] OAG_MAC_STEP2 = 16'h0002;
    localparam logic [15:0] OAG_MAC_STEP4 = 16'h0004;
    localparam logic [15:0] OAG_MAC_STEP6 = 16'h0006;

    // Literal field widths.
    localparam int OAG_SHORT_LIT_W = 8;
    localparam int OAG_DISABLE_LIT_W = 14;

    // Output values after reset.
    localparam logic [15:0] OAG_RESET_WORD = 16'h0000;

endpackage

/* File: logic/oag_ea_adder.sv */
`timescale 1ns/10ps
// Forms the effective address and the modified pointer for one operand.
module oag_ea_adder #(
    parameter int DW = 16
) (
    input  wire logic [DW-1:0] base,
    input  wire logic [DW-1:0] offset,
    input  wire logic [DW-1:0] step,
    input  wire logic [3:0]    mode,
    output logic      [DW-1:0] ea,
    output logic      [DW-1:0] new_ptr,
    output logic               modifies
);

    // Adds or subtracts the step before or after the access, or adds an
    // index or literal offset without touching the pointer.
    always_comb begin
        ea       = base;
        new_ptr  = base;
        modifies = 1'b0;
        case (mode)
            oag_pkg::OAG_POST_INC: begin
                new_ptr  = base + step;
                modifies = 1'b1;
            end
            oag_pkg::OAG_POST_DEC: begin
                new_ptr  = base - step;
                modifies = 1'b1;
            end
            oag_pkg::OAG_PRE_INC: begin
                new_ptr  = base + step;
                ea       = base + step;
                modifies = 1'b1;
            end
            oag_pkg::OAG_PRE_DEC: begin
                new_ptr  = base - step;
                ea       = base - step;
                modifies = 1'b1;
            end
            oag_pkg::OAG_INDEXED, oag_pkg::OAG_LIT_OFF: begin
                ea = base + offset;
            end
            default: begin
                ea = base;
            end
        endcase
    end

endmodule // oag_ea_adder

/* File: logic/oag_mode_check.sv */
`timescale 1ns/10ps
// Tells whether an addressing mode is defined for an instruction class.
module oag_mode_check (
    input  wire logic [2:0] cls,
    input  wire logic [3:0] mode,
    output logic            legal
);

    // Ordinary instructions lack indexed and literal operands; move adds
    // indexed and literals; accumulator class has no file direct mode.
    always_comb begin
        legal = 1'b0;
        case (cls)
            oag_pkg::OAG_CL_GENERAL: begin
                legal = (mode <= oag_pkg::OAG_PRE_DEC)
                     || (mode == oag_pkg::OAG_LIT_OFF);
            end
            oag_pkg::OAG_CL_MOVE: begin
                legal = (mode <= oag_pkg::OAG_LIT16);
            end
            oag_pkg::OAG_CL_ACCUM: begin
                legal = (mode != oag_pkg::OAG_FILE_DIR)
                     && (mode <= oag_pkg::OAG_LIT16);
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

endmodule // oag_mode_check

/* File: bench/oag_wreg_model.sv */
`timescale 1ns/10ps
// Working register file that feeds pointers and takes write-backs.
module oag_wreg_model (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic         wa_en,
    input  wire logic [3:0]   wa_idx,
    input  wire logic [15:0]  wa_data,
    input  wire logic         wb_en,
    input  wire logic [3:0]   wb_idx,
    input  wire logic [15:0]  wb_data,
    output logic      [255:0] wreg_vals
);
    // Reset loads small pointers; a write-back lands on the next edge.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                wreg_vals[16*i +: 16] <= 16'h1000 + 16'(32 * i);
            end
        end else begin
            if (wa_en) wreg_vals[16*wa_idx +: 16] <= wa_data;
            if (wb_en) wreg_vals[16*wb_idx +: 16] <= wb_data;
        end
    end
endmodule // oag_wreg_model

/* File: bench/oag_top_test.sv */
`timescale 1ns/10ps
// Drives decoder fields into the generator and judges the results.
module oag_top_test;
    logic core_clk = 0, reset = 1, instr_valid = 0, x_ptr_sel = 0;
    logic y_ptr_sel = 0, done_q, illegal_q, src_mem_q, dst_mem_q, x_rd_q;
    logic src_is_reg_q, y_rd_q, lit_valid_q, implied_q, wb_a_en_q, wb_b_en_q;
    logic clk_en = 1, dst_is_reg_q, src_is_data_q;
    logic [2:0] instr_class = 0;
    logic [3:0] src_mode = 0, dst_mode = 0, src_reg = 0, dst_reg = 0;
    logic [3:0] offset_sel = 5, wb_a_idx_q, wb_b_idx_q;
    logic [1:0] x_mac_mode = 0, y_mac_mode = 0, x_step_sel = 0, y_step_sel = 0;
    logic [15:0] lit_field = 0, file_addr = 0, src_ea_q, dst_ea_q, src_data_q;
    logic [15:0] x_addr_q, y_addr_q, lit_q, wb_a_data_q, wb_b_data_q;
    logic [255:0] wreg_vals;
    int fail_count = 0, samples_checked = 0, cycles = 0;
    oag_top dut (.core_clk, .reset, .clk_en, .instr_valid, .instr_class,
        .src_mode, .dst_mode, .src_reg, .dst_reg, .offset_sel, .lit_field,
        .file_addr, .x_ptr_sel, .y_ptr_sel, .x_mac_mode, .y_mac_mode,
        .x_step_sel, .y_step_sel, .wreg_vals, .done_q, .illegal_q, .src_mem_q,
        .dst_mem_q, .src_ea_q, .dst_ea_q, .src_is_reg_q, .dst_is_reg_q,
        .src_is_data_q, .src_data_q, .x_rd_q, .x_addr_q, .y_rd_q, .y_addr_q,
        .lit_valid_q, .lit_q, .implied_q, .wb_a_en_q, .wb_a_idx_q,
        .wb_a_data_q, .wb_b_en_q, .wb_b_idx_q, .wb_b_data_q);
    oag_wreg_model regs (.core_clk, .reset, .wa_en(wb_a_en_q),
        .wa_idx(wb_a_idx_q), .wa_data(wb_a_data_q), .wb_en(wb_b_en_q),
        .wb_idx(wb_b_idx_q), .wb_data(wb_b_data_q), .wreg_vals);
    // Clock toggles every half period; a cycle ceiling cuts a hang short.
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            close_out();
        end
    end
    function automatic logic [15:0] rv(int i);
        return 16'h1000 + 16'(32 * i);
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One idle cycle lets write-backs land before the next instruction.
    task automatic go(logic [2:0] c, logic [3:0] s, logic [3:0] d);
        @(negedge core_clk);
        instr_class = c;
        src_mode = s;
        dst_mode = d;
        instr_valid = 1;
        @(negedge core_clk);
        instr_valid = 0;
    endtask
    task automatic t_general();
        file_addr = 16'h0ABC;
        go(3'h1, 4'h0, 4'h0);
        chk({done_q, src_mem_q, src_ea_q}, 18'h30ABC);
        src_reg = 2;
        go(3'h1, 4'h3, 4'h0);
        chk(src_ea_q, rv(2));
        chk(wb_a_data_q, rv(2) + 16'h0002);
        chk({wb_a_en_q, wb_a_idx_q}, {1'b1, 4'h2});
        go(3'h1, 4'h6, 4'h0);
        chk(src_ea_q, rv(2));
        src_reg = 3;
        go(3'h1, 4'h1, 4'h0);
        chk({src_is_reg_q, src_mem_q, src_data_q}, 18'h20000 | rv(3));
        go(3'h1, 4'h2, 4'h0);
        chk({src_mem_q, src_ea_q, wb_a_en_q}, {1'b1, rv(3), 1'b0});
        go(3'h1, 4'h7, 4'h0);
        chk({illegal_q, src_mem_q}, 2'b10);
        $display("t_general finished");
    endtask
    task automatic t_move();
        src_reg = 4;
        dst_reg = 6;
        lit_field = 16'h0010;
        go(3'h2, 4'h7, 4'h8);
        chk(src_ea_q, rv(4) + rv(5));
        chk(dst_ea_q, rv(6) + 16'h0010);
        chk({src_mem_q, dst_mem_q}, 2'b11);
        lit_field = 16'h12A5;
        go(3'h3, 4'h9, 4'h1);
        chk(src_data_q, 16'h00A5);
        chk({src_is_data_q, dst_is_reg_q, dst_mem_q}, 3'b110);
        go(3'h3, 4'hA, 4'h1);
        chk(src_data_q, 16'h12A5);
        go(3'h2, 4'h1, 4'h5);
        chk(src_data_q, rv(4));
        chk({dst_ea_q, wb_b_en_q, wb_b_idx_q}, {rv(6) + 16'h0002, 5'h16});
        chk(wb_b_data_q, rv(6) + 16'h0002);
        $display("t_move finished");
    endtask
    task automatic t_mac();
        logic [15:0] p;
        p = rv(8);
        x_mac_mode = 1;
        y_ptr_sel = 1;
        y_mac_mode = 2;
        for (int k = 0; k < 3; k++) begin
            x_step_sel = 2'(k);
            go(3'h4, 4'h0, 4'h0);
            chk({x_rd_q, y_rd_q, x_addr_q}, 18'h30000 | p);
            chk(y_addr_q, rv(11) + rv(5));
            p = p + 16'(2 * k + 2);
            chk(wb_a_data_q, p);
            chk({wb_a_en_q, wb_a_idx_q, wb_b_en_q}, {1'b1, 4'h8, 1'b0});
        end
        x_mac_mode = 2;
        go(3'h4, 4'h0, 4'h0);
        chk({illegal_q, x_rd_q}, 2'b10);
        x_mac_mode = 0;
        y_mac_mode = 0;
        go(3'h4, 4'h0, 4'h0);
        chk({x_addr_q, y_addr_q}, {p, rv(11)});
        $display("t_mac finished");
    endtask
    task automatic t_other();
        lit_field = 16'hFF80;
        go(3'h5, 4'h0, 4'h0);
        chk({lit_valid_q, lit_q}, 17'h1FF80);
        lit_field = 16'hFFFF;
        go(3'h6, 4'h0, 4'h0);
        chk(lit_q, 16'h3FFF);
        go(3'h7, 4'h0, 4'h0);
        chk({implied_q, src_mem_q}, 2'b10);
        go(3'h0, 4'h0, 4'h0);
        chk({done_q, src_mem_q, x_rd_q, illegal_q}, 4'h8);
        // With the enable low every output keeps its last value.
        clk_en = 0;
        lit_field = 16'h1234;
        go(3'h5, 4'h0, 4'h0);
        chk({done_q, lit_valid_q, lit_q}, 18'h23FFF);
        clk_en = 1;
        $display("t_other finished");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Reset for ten cycles, then run every scenario.
    initial begin
        repeat (10) @(negedge core_clk);
        reset = 0;
        chk({done_q, src_ea_q}, 17'h00000);
        t_general();
        t_move();
        t_mac();
        t_other();
        close_out();
    end
endmodule // oag_top_test
